/* rtl/oag_top.v */
// Operand and effective-address generator with executive-call sequencer
//
// Local design decisions: the strobed register port and the register addresses.
`include "oag_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module oag_top #(
   parameter W = `OAG_W
) (
   input  wire          clk,
   input  wire          nrst,
   input  wire [3:0]    reg_addr,
   input  wire [15:0]   reg_wdata,
   input  wire          reg_wr,
   input  wire          reg_rd,
   output reg  [15:0]   reg_rdata,
   input  wire          instr_valid,
   input  wire [3:0]    mode_sel,
   input  wire [1:0]    op_words,
   input  wire [W-1:0]  instr_word,
   input  wire [W-1:0]  second_word,
   input  wire [16*W-1:0] gpr_flat,
   output wire          busy,
   output reg           result_valid,
   output reg  [W-1:0]  effective_address,
   output reg  [W-1:0]  effective_address_1,
   output reg  [W-1:0]  effective_address_2,
   output reg  [W-1:0]  operand,
   output reg           operand_is_reg,
   output reg           operand_is_imm,
   output reg  [3:0]    opnd_reg,
   output reg  [3:0]    opnd_reg_next,
   output reg  [3:0]    opcode_extension,
   output reg  [7:0]    opcode,
   output reg  [3:0]    dest_reg_field,
   output wire [3:0]    segment_select,
   output reg           int_enable,
   output reg  [W-1:0]  mem_addr,
   output reg  [W-1:0]  mem_wdata,
   output reg           mem_wr,
   output reg           mem_rd,
   input  wire [W-1:0]  mem_rdata,
   input  wire          fp_valid,
   input  wire          fp_extended,
   input  wire [W-1:0]  fp_word0,
   input  wire [W-1:0]  fp_word1,
   input  wire [W-1:0]  fp_word2,
   output reg  [39:0]   fp_mantissa,
   output reg  [7:0]    fp_exponent
);
   localparam S_IDLE = 4'h0;
   localparam S_IND  = 4'h1;
   localparam S_INDC = 4'h2;
   localparam S_W0   = 4'h3;
   localparam S_W1   = 4'h4;
   localparam S_W2   = 4'h5;
   localparam S_R0   = 4'h6;
   localparam S_R1   = 4'h7;
   localparam S_R2   = 4'h8;
   localparam S_R3   = 4'h9;

   reg  [1:0]   rst_sync;
   wire         rst_n = rst_sync[1];
   reg  [3:0]   state;
   reg  [15:0]  system_config_register;
   reg  [15:0]  fault_reg;
   reg  [15:0]  pending_interrupt_register;
   reg  [15:0]  interrupt_mask;
   reg  [15:0]  status_word;
   reg  [15:0]  instruction_counter;
   reg  [15:0]  link_ptr;
   reg  [15:0]  svc_ptr;
   reg  [3:0]   exec_n;
   reg  [W-1:0] next_ea;
   reg  [W-1:0] next_opnd;
   reg          next_is_imm;
   reg          next_is_reg;
   reg          next_ind;

   // Index value, a zero field gives no indexing
   function [W-1:0] idx_val;
      input [3:0]      f;
      input [16*W-1:0] g;
      begin
         idx_val = (f == 4'h0) ? {W{1'b0}} : g[f*W +: W];
      end
   endfunction

   function [W-1:0] gpr;
      input [3:0]      f;
      input [16*W-1:0] g;
      begin
         gpr = g[f*W +: W];
      end
   endfunction

   wire [3:0] f1  = instr_word[`OAG_F1_HI:`OAG_F1_LO];
   wire [3:0] f2  = instr_word[`OAG_F2_HI:`OAG_F2_LO];
   wire [7:0] du  = instr_word[`OAG_DU_HI:`OAG_DU_LO];
   wire [3:0] brn = {2'b00, instr_word[`OAG_BR_HI:`OAG_BR_LO]}
                    + `OAG_BASE_OFS;
   wire [W-1:0] base_val = gpr(brn, gpr_flat);
   wire [W-1:0] short_v  = {{(W-4){1'b0}}, f2} + `OAG_ONE16;
   wire       seg_en = system_config_register[`OAG_SCR_AS_EN];
   wire       take   = instr_valid && (state == S_IDLE);

   assign busy = (state != S_IDLE);
   // Segment drives the address state only when segments are enabled
   assign segment_select = seg_en ?
          status_word[`OAG_SEG_HI:`OAG_SEG_LO] : 4'h0;

   always @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         rst_sync <= 2'b00;
      end else begin
         rst_sync <= {rst_sync[0], 1'b1};
      end
   end

   // Sums are W bits wide, so every address wraps in its space
   always @* begin
      next_ea     = {W{1'b0}};
      next_opnd   = {W{1'b0}};
      next_is_imm = 1'b0;
      next_is_reg = 1'b0;
      next_ind    = 1'b0;
      case (mode_sel)
         `OAG_M_REG: begin
            next_is_reg = 1'b1;
            next_opnd   = gpr(f2, gpr_flat);
         end
         `OAG_M_DIRECT: begin
            next_ea = second_word + idx_val(f2, gpr_flat);
         end
         `OAG_M_INDIRECT: begin
            next_ea  = second_word + idx_val(f2, gpr_flat);
            next_ind = 1'b1;
         end
         `OAG_M_LONG_LIT: begin
            next_is_imm = 1'b1;
            next_opnd   = second_word;
         end
         `OAG_M_LONG_IDX: begin
            next_is_imm = 1'b1;
            next_opnd   = second_word + idx_val(f2, gpr_flat);
         end
         `OAG_M_SHORT_POS: begin
            next_is_imm = 1'b1;
            next_opnd   = short_v;
         end
         `OAG_M_SHORT_NEG: begin
            next_is_imm = 1'b1;
            next_opnd   = {W{1'b0}} - short_v;
         end
         `OAG_M_CNT_REL: begin
            next_ea = {{(W-8){du[7]}}, du}
                      + instruction_counter - `OAG_ONE16;
         end
         `OAG_M_BASE: begin
            next_ea = base_val + {{(W-8){1'b0}}, du};
         end
         `OAG_M_BASE_IDX: begin
            next_ea = base_val + idx_val(f2, gpr_flat);
         end
         default: begin
            next_ea = {W{1'b0}};
         end
      endcase
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         state               <= S_IDLE;
         result_valid        <= 1'b0;
         effective_address   <= `OAG_RST16;
         effective_address_1 <= `OAG_RST16;
         effective_address_2 <= `OAG_RST16;
         operand             <= `OAG_RST16;
         operand_is_reg      <= 1'b0;
         operand_is_imm      <= 1'b0;
         opnd_reg            <= 4'h0;
         opnd_reg_next       <= 4'h0;
         opcode_extension    <= 4'h0;
         opcode              <= 8'h00;
         dest_reg_field      <= 4'h0;
         mem_addr            <= `OAG_RST16;
         mem_wdata           <= `OAG_RST16;
         mem_wr              <= 1'b0;
         mem_rd              <= 1'b0;
         exec_n              <= 4'h0;
      end else begin
         result_valid <= 1'b0;
         mem_wr       <= 1'b0;
         mem_rd       <= 1'b0;
         case (state)
            S_IDLE: begin
               if (take) begin
                  opcode           <= instr_word[`OAG_OPC_HI:`OAG_OPC_LO];
                  dest_reg_field   <= f1;
                  opcode_extension <= (mode_sel == `OAG_M_BASE_IDX) ?
                                      f1 : f2;
                  opnd_reg         <= f2;
                  opnd_reg_next    <= f2 + 4'h1;
                  operand          <= next_opnd;
                  operand_is_reg   <= next_is_reg;
                  operand_is_imm   <= next_is_imm;
                  exec_n           <= f2;
                  if (mode_sel == `OAG_M_EXEC) begin
                     state <= S_W0;
                  end else if (next_ind) begin
                     mem_addr <= next_ea;
                     mem_rd   <= 1'b1;
                     state    <= S_IND;
                  end else begin
                     effective_address   <= next_ea;
                     effective_address_1 <= next_ea + `OAG_ONE16;
                     effective_address_2 <= next_ea + `OAG_TWO16;
                     result_valid        <= 1'b1;
                  end
               end
            end
            S_IND: begin
               state <= S_INDC;
            end
            S_INDC: begin
               // Pointer word arrives one cycle after the read
               effective_address   <= mem_rdata;
               effective_address_1 <= mem_rdata + `OAG_ONE16;
               effective_address_2 <= mem_rdata + `OAG_TWO16;
               result_valid        <= 1'b1;
               state               <= S_IDLE;
            end
            S_W0: begin
               mem_addr  <= link_ptr;
               mem_wdata <= interrupt_mask;
               mem_wr    <= 1'b1;
               state     <= S_W1;
            end
            S_W1: begin
               mem_addr  <= link_ptr + `OAG_ONE16;
               mem_wdata <= status_word;
               mem_wr    <= 1'b1;
               state     <= S_W2;
            end
            S_W2: begin
               mem_addr  <= link_ptr + `OAG_TWO16;
               mem_wdata <= instruction_counter;
               mem_wr    <= 1'b1;
               state     <= S_R0;
            end
            S_R0: begin
               mem_addr <= svc_ptr;
               mem_rd   <= 1'b1;
               state    <= S_R1;
            end
            S_R1: begin
               mem_addr <= svc_ptr + `OAG_ONE16;
               mem_rd   <= 1'b1;
               state    <= S_R2;
            end
            S_R2: begin
               mem_addr <= svc_ptr + `OAG_TWO16
                           + {{(W-4){1'b0}}, exec_n};
               mem_rd   <= 1'b1;
               state    <= S_R3;
            end
            S_R3: begin
               result_valid <= 1'b1;
               state        <= S_IDLE;
            end
            default: begin
               state <= S_IDLE;
            end
         endcase
      end
   end

   // Loads from the service area land one cycle after each read
   reg  mem_rd_q;
   wire ld_mk = (state == S_R2);
   wire ld_sw = (state == S_R3);
   // Counter word of the last read arrives once the sequencer is idle
   wire ld_ic = (state == S_IDLE) && mem_rd_q;
   wire sw_wr = reg_wr && (reg_addr == `OAG_A_SW);
   wire seg_chg = sw_wr && (reg_wdata[`OAG_SEG_HI:`OAG_SEG_LO]
                  != status_word[`OAG_SEG_HI:`OAG_SEG_LO]);
   wire fault_w1c = reg_wr && (reg_addr == `OAG_A_FAULT)
                    && reg_wdata[`OAG_FAULT_AS];
   wire pir_w1c = reg_wr && (reg_addr == `OAG_A_PIR)
                  && reg_wdata[`OAG_PIR_EXEC];
   wire exec_go = take && (mode_sel == `OAG_M_EXEC);

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         mem_rd_q                   <= 1'b0;
         system_config_register     <= `OAG_RST16;
         fault_reg                  <= `OAG_RST16;
         pending_interrupt_register <= `OAG_RST16;
         interrupt_mask             <= `OAG_RST16;
         status_word                <= `OAG_RST16;
         instruction_counter        <= `OAG_RST16;
         link_ptr                   <= `OAG_RST16;
         svc_ptr                    <= `OAG_RST16;
         int_enable                 <= 1'b0;
      end else begin
         mem_rd_q <= (state == S_R3);
         if (reg_wr && reg_addr == `OAG_A_SCR) begin
            system_config_register <= reg_wdata;
         end
         // Hardware set wins over a software clear in the same cycle
         if (seg_chg && !seg_en) begin
            fault_reg[`OAG_FAULT_AS] <= 1'b1;
         end else if (fault_w1c) begin
            fault_reg[`OAG_FAULT_AS] <= 1'b0;
         end
         if (exec_go) begin
            pending_interrupt_register[`OAG_PIR_EXEC] <= 1'b1;
         end else if (pir_w1c) begin
            pending_interrupt_register[`OAG_PIR_EXEC] <= 1'b0;
         end
         if (ld_mk) begin
            interrupt_mask <= mem_rdata;
         end else if (reg_wr && reg_addr == `OAG_A_MASK) begin
            interrupt_mask <= reg_wdata;
         end
         if (ld_sw) begin
            status_word <= mem_rdata;
         end else if (sw_wr) begin
            // Blocked segment bits keep their old value
            status_word <= seg_en ? reg_wdata :
               {reg_wdata[W-1:`OAG_SEG_HI+1],
                status_word[`OAG_SEG_HI:`OAG_SEG_LO]};
         end
         if (ld_ic) begin
            instruction_counter <= mem_rdata;
         end else if (reg_wr && reg_addr == `OAG_A_IC) begin
            instruction_counter <= reg_wdata;
         end
         if (reg_wr && reg_addr == `OAG_A_LINK) begin
            link_ptr <= reg_wdata;
         end
         if (reg_wr && reg_addr == `OAG_A_SVC) begin
            svc_ptr <= reg_wdata;
         end
         if (exec_go) begin
            int_enable <= 1'b0;
         end else if (reg_wr && reg_addr == `OAG_A_STAT) begin
            int_enable <= reg_wdata[0];
         end
      end
   end

   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         reg_rdata <= `OAG_RST16;
      end else if (reg_rd) begin
         case (reg_addr)
            `OAG_A_SCR:   reg_rdata <= system_config_register;
            `OAG_A_FAULT: reg_rdata <= fault_reg;
            `OAG_A_PIR:   reg_rdata <= pending_interrupt_register;
            `OAG_A_MASK:  reg_rdata <= interrupt_mask;
            `OAG_A_SW:    reg_rdata <= status_word;
            `OAG_A_IC:    reg_rdata <= instruction_counter;
            `OAG_A_LINK:  reg_rdata <= link_ptr;
            `OAG_A_SVC:   reg_rdata <= svc_ptr;
            `OAG_A_STAT:  reg_rdata <= {state, 11'h000, int_enable};
            default:      reg_rdata <= `OAG_RST16;
         endcase
      end else begin
         reg_rdata <= `OAG_RST16;
      end
   end

   // Floating layout: word 0 and high byte of word 1 hold the mantissa,
   // low byte of word 1 the exponent, word 2 the extended mantissa tail
   always @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         fp_mantissa <= 40'h0000000000;
         fp_exponent <= 8'h00;
      end else if (fp_valid) begin
         fp_exponent <= fp_word1[`OAG_EXP_HI:`OAG_EXP_LO];
         fp_mantissa <= {fp_word0, fp_word1[`OAG_MHI_HI:`OAG_MHI_LO],
                         fp_extended ? fp_word2 : 16'h0000};
      end
   end
endmodule
`default_nettype wire

/* shared/oag_defines.vh */
// Constants for the operand and effective-address generator
`ifndef OAG_DEFINES_VH
`define OAG_DEFINES_VH
`define OAG_W            16
// Instruction fields, bit 15 is the word MSB
`define OAG_OPC_HI       15
`define OAG_OPC_LO       8
`define OAG_F1_HI        7
`define OAG_F1_LO        4
`define OAG_F2_HI        3
`define OAG_F2_LO        0
`define OAG_BR_HI        9
`define OAG_BR_LO        8
`define OAG_DU_HI        7
`define OAG_DU_LO        0
`define OAG_BASE_OFS     4'hC
// Addressing mode codes on mode_sel
`define OAG_M_REG        4'h0
`define OAG_M_DIRECT     4'h1
`define OAG_M_INDIRECT   4'h2
`define OAG_M_LONG_LIT   4'h3
`define OAG_M_LONG_IDX   4'h4
`define OAG_M_SHORT_POS  4'h5
`define OAG_M_SHORT_NEG  4'h6
`define OAG_M_CNT_REL    4'h7
`define OAG_M_BASE       4'h8
`define OAG_M_BASE_IDX   4'h9
`define OAG_M_EXEC       4'hA
// Register indexes, byte address is index times four
`define OAG_A_SCR        4'h0
`define OAG_A_FAULT      4'h1
`define OAG_A_PIR        4'h2
`define OAG_A_MASK       4'h3
`define OAG_A_SW         4'h4
`define OAG_A_IC         4'h5
`define OAG_A_LINK       4'h6
`define OAG_A_SVC        4'h7
`define OAG_A_STAT       4'h8
// Bit positions
`define OAG_SCR_AS_EN    0
`define OAG_FAULT_AS     11
`define OAG_PIR_EXEC     5
`define OAG_SEG_HI       3
`define OAG_SEG_LO       0
// Reset value and word increments
`define OAG_RST16        16'h0000
`define OAG_ONE16        16'h0001
`define OAG_TWO16        16'h0002
// Floating-point word layout
`define OAG_EXP_HI       7
`define OAG_EXP_LO       0
`define OAG_MHI_HI       15
`define OAG_MHI_LO       8
`endif

/* verification/oag_top_monitor.sv */
// Assertion checker for the operand address generator ports
`include "oag_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module oag_top_monitor #(
   parameter W = 16
) (
   input wire logic            clk,
   input wire logic            nrst,
   input wire logic            instr_valid,
   input wire logic [3:0]      mode_sel,
   input wire logic [W-1:0]    instr_word,
   input wire logic [W-1:0]    second_word,
   input wire logic [16*W-1:0] gpr_flat,
   input wire logic            busy,
   input wire logic            result_valid,
   input wire logic [W-1:0]    effective_address,
   input wire logic [W-1:0]    effective_address_1,
   input wire logic [W-1:0]    effective_address_2,
   input wire logic [W-1:0]    operand,
   input wire logic            operand_is_reg,
   input wire logic [3:0]      opnd_reg,
   input wire logic [3:0]      opnd_reg_next,
   input wire logic [3:0]      opcode_extension,
   input wire logic            int_enable,
   input wire logic [W-1:0]    mem_addr,
   input wire logic            mem_wr,
   input wire logic            mem_rd,
   input wire logic [W-1:0]    mem_rdata,
   input wire logic            fp_valid,
   input wire logic            fp_extended,
   input wire logic [W-1:0]    fp_word0,
   input wire logic [W-1:0]    fp_word1,
   input wire logic [W-1:0]    fp_word2,
   input wire logic [39:0]     fp_mantissa,
   input wire logic [7:0]      fp_exponent
);
   logic          take;
   logic [3:0]    f1;
   logic [3:0]    f2;
   logic [W-1:0]  idx_val;
   logic [W-1:0]  base_val;
   logic [W-1:0]  dir_sum;
   logic [W-1:0]  base_disp;
   logic [W-1:0]  base_idx;
   logic [W-1:0]  short_pos;
   logic [W-1:0]  short_val;
   logic [7:0]    exp_in;
   logic [39:0]   mant_in;
   assign take      = instr_valid && !busy;
   assign f1        = instr_word[7:4];
   assign f2        = instr_word[3:0];
   // Register zero never indexes, so a zero field adds nothing
   assign idx_val   = (f2 == 4'h0) ? '0 : gpr_flat[W*f2 +: W];
   assign base_val  = gpr_flat[W*(12 + instr_word[9:8]) +: W];
   assign dir_sum   = second_word + idx_val;
   assign base_disp = base_val + {8'h00, instr_word[7:0]};
   assign base_idx  = base_val + idx_val;
   assign short_pos = {12'h000, f2} + 16'h0001;
   assign short_val = (mode_sel == `OAG_M_SHORT_NEG) ?
                      16'h0000 - short_pos : short_pos;
   assign exp_in    = fp_word1[7:0];
   assign mant_in   = {fp_word0, fp_word1[15:8],
                       fp_extended ? fp_word2 : 16'h0000};
   default clocking cb @(posedge clk);
   endclocking
   default disable iff (!nrst);
   a_reg_fields: assert property (take && mode_sel == `OAG_M_REG |=>
      operand_is_reg && opnd_reg == $past(f2)
      && opnd_reg_next == $past(f2) + 4'h1)
      else $error("register operand fields wrong");
   a_direct_addr: assert property (take && mode_sel == `OAG_M_DIRECT |=>
      result_valid && effective_address == $past(dir_sum))
      else $error("direct address wrong");
   a_long_index: assert property (take && mode_sel == `OAG_M_LONG_IDX |=>
      operand == $past(dir_sum))
      else $error("indexed literal wrong");
   a_short_imm: assert property (take && (mode_sel == `OAG_M_SHORT_POS
      || mode_sel == `OAG_M_SHORT_NEG) |=> operand == $past(short_val))
      else $error("short literal wrong");
   a_base_addr: assert property (take && mode_sel == `OAG_M_BASE |=>
      effective_address == $past(base_disp))
      else $error("base relative address wrong");
   a_base_index: assert property (take && mode_sel == `OAG_M_BASE_IDX |=>
      effective_address == $past(base_idx)
      && opcode_extension == $past(f1))
      else $error("indexed base address wrong");
   a_next_words: assert property (result_valid |->
      effective_address_1 == effective_address + 16'h0001
      && effective_address_2 == effective_address + 16'h0002)
      else $error("following word addresses wrong");
   a_indirect_read: assert property (take && mode_sel == `OAG_M_INDIRECT
      |=> mem_rd && mem_addr == $past(dir_sum) ##2 result_valid)
      else $error("pointer fetch wrong");
   a_indirect_ea: assert property (result_valid && $past(mem_rd, 2)
      && !$past(mem_rd) |-> effective_address == $past(mem_rdata))
      else $error("pointer not used as address");
   a_exec_seq: assert property (take && mode_sel == `OAG_M_EXEC |=>
      !int_enable && busy ##1 mem_wr [*3] ##1 mem_rd [*3] ##1 result_valid)
      else $error("executive call sequence wrong");
   a_float_split: assert property (fp_valid |=>
      fp_exponent == $past(exp_in) && fp_mantissa == $past(mant_in))
      else $error("float unpacking wrong");
   c_exec: cover property (take && mode_sel == `OAG_M_EXEC);
   c_indirect: cover property (take && mode_sel == `OAG_M_INDIRECT);
   c_float_ext: cover property (fp_valid && fp_extended);
endmodule
bind oag_top oag_top_monitor #(.W(W)) oag_top_monitor_inst (
   .clk, .nrst, .instr_valid, .mode_sel, .instr_word, .second_word,
   .gpr_flat, .busy, .result_valid, .effective_address,
   .effective_address_1, .effective_address_2, .operand, .operand_is_reg,
   .opnd_reg, .opnd_reg_next, .opcode_extension, .int_enable, .mem_addr,
   .mem_wr, .mem_rd, .mem_rdata, .fp_valid, .fp_extended, .fp_word0,
   .fp_word1, .fp_word2, .fp_mantissa, .fp_exponent
);
`default_nettype wire

/* verification/oag_top_tb_top.sv */
// Self-checking bench for the operand address generator
`include "oag_defines.vh"
`timescale 1ns/1ps
`default_nettype none
module oag_top_tb_top;
   logic          clk, nrst, reg_wr, reg_rd, instr_valid, busy, result_valid;
   logic          operand_is_reg, operand_is_imm, int_enable, mem_wr, mem_rd;
   logic          fp_valid, fp_extended;
   logic [1:0]    op_words;
   logic [3:0]    reg_addr, mode_sel, opnd_reg, opnd_reg_next;
   logic [3:0]    opcode_extension, dest_reg_field, segment_select;
   logic [7:0]    opcode, fp_exponent;
   logic [15:0]   reg_wdata, reg_rdata, instr_word, second_word, operand;
   logic [15:0]   effective_address, effective_address_1, effective_address_2;
   logic [15:0]   mem_addr, mem_wdata, mem_rdata, fp_word0, fp_word1, fp_word2;
   logic [39:0]   fp_mantissa;
   logic [255:0]  gpr_flat;
   logic [15:0]   wq[$];
   int            miscompares, compares;
   oag_top oag_top_inst (
      .clk, .nrst, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
      .instr_valid, .mode_sel, .op_words, .instr_word, .second_word,
      .gpr_flat, .busy, .result_valid, .effective_address,
      .effective_address_1, .effective_address_2, .operand,
      .operand_is_reg, .operand_is_imm, .opnd_reg, .opnd_reg_next,
      .opcode_extension, .opcode, .dest_reg_field, .segment_select,
      .int_enable, .mem_addr, .mem_wdata, .mem_wr, .mem_rd, .mem_rdata,
      .fp_valid, .fp_extended, .fp_word0, .fp_word1, .fp_word2,
      .fp_mantissa, .fp_exponent
   );
   initial begin
      clk = 1'b0;
      forever #10 clk = ~clk;
   end
   // Memory answers with a scrambled address so a stale word is caught
   always @(posedge clk) begin
      mem_rdata <= mem_rd ? mem_addr ^ 16'h5A5A : ~mem_rdata;
      if (mem_wr === 1'b1) begin
         wq.push_back(mem_addr);
         wq.push_back(mem_wdata);
      end
   end
   function automatic logic [15:0] gv(input int k);
      return 16'h1111 * k[15:0];
   endfunction
   task automatic final_report;
      $display("compares=%0d miscompares=%0d", compares, miscompares);
      if (miscompares == 0 && compares > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask
   task automatic cmp(input logic [15:0] g, input logic [15:0] e);
      compares++;
      if (g !== e) begin
         miscompares++;
         $display("FAIL t=%0t got=%h exp=%h", $time, g, e);
      end
   endtask
   task automatic wr(input logic [3:0] a, input logic [15:0] d);
      @(posedge clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge clk);
      reg_wr <= 1'b0;
   endtask
   task automatic rd(input logic [3:0] a, input logic [15:0] e);
      @(posedge clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge clk);
      reg_rd <= 1'b0;
      @(negedge clk);
      cmp(reg_rdata, e);
   endtask
   task automatic run(input logic [3:0] m, input logic [15:0] iw, sw);
      int n;
      @(posedge clk);
      mode_sel <= m;
      instr_word <= iw;
      second_word <= sw;
      instr_valid <= 1'b1;
      @(posedge clk);
      instr_valid <= 1'b0;
      n = 0;
      do begin
         @(negedge clk);
         n++;
      end while (result_valid !== 1'b1 && n < 20);
      if (n >= 20) begin
         miscompares++;
         final_report;
      end
   endtask
   task automatic t_regs;
      for (int a = 0; a < 9; a++)
         rd(a[3:0], 16'h0000);
      wr(4'hC, 16'hFFFF);
      rd(4'hC, 16'h0000);
   endtask
   task automatic t_segment;
      wr(`OAG_A_SW, 16'h0003);
      rd(`OAG_A_FAULT, 16'h0001 << `OAG_FAULT_AS);
      cmp({12'h000, segment_select}, 16'h0000);
      wr(`OAG_A_FAULT, 16'h0001 << `OAG_FAULT_AS);
      wr(`OAG_A_SCR, 16'h0001);
      wr(`OAG_A_SW, 16'h0005);
      rd(`OAG_A_FAULT, 16'h0000);
      cmp({12'h000, segment_select}, 16'h0005);
   endtask
   task automatic t_modes;
      wr(`OAG_A_IC, 16'h0100);
      run(`OAG_M_REG, 16'h5A3F, 16'h0000);
      cmp({opcode, dest_reg_field, opnd_reg}, 16'h5A3F);
      cmp(operand, gv(15));
      cmp({14'h0000, operand_is_reg, operand_is_imm}, 16'h0002);
      cmp({12'h000, opnd_reg_next}, 16'h0000);
      run(`OAG_M_DIRECT, 16'h0000, 16'hFFFF);
      cmp(effective_address, 16'hFFFF);
      cmp(effective_address_1, 16'h0000);
      cmp(effective_address_2, 16'h0001);
      rd(`OAG_A_FAULT, 16'h0000);
      run(`OAG_M_DIRECT, 16'h000F, 16'h0002);
      cmp(effective_address, 16'h0002 + gv(15));
      run(`OAG_M_LONG_LIT, 16'h0007, 16'hABCD);
      cmp(operand, 16'hABCD);
      cmp({14'h0000, operand_is_reg, operand_is_imm}, 16'h0001);
      cmp({12'h000, opcode_extension}, 16'h0007);
      run(`OAG_M_LONG_IDX, 16'h0002, 16'h0100);
      cmp(operand, 16'h0100 + gv(2));
      run(`OAG_M_LONG_IDX, 16'h0000, 16'h0100);
      cmp(operand, 16'h0100);
      for (int i = 0; i < 16; i += 15) begin
         run(`OAG_M_SHORT_POS, i[15:0], 16'h0000);
         cmp(operand, i[15:0] + 16'h0001);
         run(`OAG_M_SHORT_NEG, i[15:0], 16'h0000);
         cmp(operand, 16'h0000 - i[15:0] - 16'h0001);
      end
      run(`OAG_M_CNT_REL, 16'h0080, 16'h0000);
      cmp(effective_address, 16'hFF80 + 16'h0100 - 16'h0001);
      run(`OAG_M_CNT_REL, 16'h007F, 16'h0000);
      cmp(effective_address, 16'h007F + 16'h0100 - 16'h0001);
      run(`OAG_M_BASE, 16'h03FF, 16'h0000);
      cmp(effective_address, gv(15) + 16'h00FF);
      run(`OAG_M_BASE, 16'h0010, 16'h0000);
      cmp(effective_address, gv(12) + 16'h0010);
      run(`OAG_M_BASE_IDX, 16'h0160, 16'h0000);
      cmp(effective_address, gv(13));
      cmp({12'h000, opcode_extension}, 16'h0006);
      run(`OAG_M_BASE_IDX, 16'h0161, 16'h0000);
      cmp(effective_address, gv(13) + gv(1));
      run(`OAG_M_INDIRECT, 16'h0001, 16'h0040);
      cmp(effective_address, (16'h0040 + gv(1)) ^ 16'h5A5A);
   endtask
   task automatic t_exec;
      logic [15:0] sv [3] = '{16'h0011, 16'h0005, 16'h0100};
      wr(`OAG_A_MASK, 16'h0011);
      wr(`OAG_A_LINK, 16'h0200);
      wr(`OAG_A_SVC, 16'h0300);
      wr(`OAG_A_STAT, 16'h0001);
      wq.delete();
      run(`OAG_M_EXEC, 16'h0003, 16'h0000);
      repeat (2) @(negedge clk);
      cmp(16'(wq.size()), 16'h0006);
      for (int i = 0; i < 3; i++) begin
         cmp(wq[2*i], 16'h0200 + i[15:0]);
         cmp(wq[2*i+1], sv[i]);
      end
      cmp({15'h0000, int_enable}, 16'h0000);
      rd(`OAG_A_PIR, 16'h0001 << `OAG_PIR_EXEC);
      rd(`OAG_A_MASK, 16'h0300 ^ 16'h5A5A);
      rd(`OAG_A_SW, 16'h0301 ^ 16'h5A5A);
      rd(`OAG_A_IC, (16'h0302 + 16'h0003) ^ 16'h5A5A);
      cmp({12'h000, segment_select}, (16'h0301 ^ 16'h5A5A) & 16'h000F);
   endtask
   task automatic t_float;
      for (int e = 1; e >= 0; e--) begin
         @(posedge clk);
         fp_word0 <= 16'h4000;
         fp_word1 <= 16'hA503;
         fp_word2 <= 16'h1234;
         fp_extended <= e[0];
         fp_valid <= 1'b1;
         @(posedge clk);
         fp_valid <= 1'b0;
         @(negedge clk);
         cmp(fp_mantissa[39:24], 16'h4000);
         cmp(fp_mantissa[23:8], e ? 16'hA512 : 16'hA500);
         cmp({fp_mantissa[7:0], fp_exponent}, e ? 16'h3403 : 16'h0003);
      end
   endtask
   initial begin
      nrst = 1'b0;
      {reg_wr, reg_rd, instr_valid, fp_valid, fp_extended} = 5'h00;
      {reg_addr, mode_sel} = 8'h00;
      {reg_wdata, instr_word, second_word} = 48'h0;
      {fp_word0, fp_word1, fp_word2} = 48'h0;
      op_words = 2'h1;
      for (int k = 0; k < 16; k++)
         gpr_flat[16*k +: 16] = gv(k);
      repeat (8) @(posedge clk);
      nrst <= 1'b1;
      repeat (3) @(posedge clk);
      t_regs;
      t_segment;
      t_modes;
      t_exec;
      t_float;
      final_report;
   end
endmodule
`default_nettype wire
